// *** hdl/usb_irq_pkg.sv ***
// Constants for the USB device interrupt logic: map, fields, resets, timing.
// Assumes a single 50 MHz core clock; all users import the whole package.
package usb_irq_pkg;
  // ----------------------------------------------------------------------
  // Register map (byte addresses, low byte decoded)
  // ----------------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h00;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h04;
  localparam logic [7:0] OFS_MODE = 8'h08;
  localparam logic [7:0] OFS_HW_CONFIG = 8'h0c;
  localparam logic [1:0] EP_STATUS_PAGE = 2'h1;
  // ----------------------------------------------------------------------
  // Interrupt register fields
  // ----------------------------------------------------------------------
  localparam int FLAG_W = 24;
  localparam int EVT_W = 7;
  localparam int NUM_EP = 16;
  localparam int BIT_BUS_RESET = 0;
  localparam int BIT_RESUME = 1;
  localparam int BIT_SUSPEND_ENTRY = 2;
  localparam int BIT_XFER_END = 3;
  localparam int BIT_SOF = 4;
  localparam int BIT_PSEUDO = 5;
  localparam int BIT_SHORT_END = 6;
  localparam int BIT_BUS_STATE = 7;
  localparam int BIT_EP_BASE = 8;
  localparam logic [FLAG_W-1:0] IRQ_SRC_MASK = 24'hffff7f;
  localparam logic [EVT_W-1:0] CLEAR_ON_READ = 7'h7f;
  localparam int MODE_GLOBAL_EN_BIT = 0;
  localparam int CFG_POL_BIT = 0;
  localparam int CFG_PULSE_BIT = 1;
  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [FLAG_W-1:0] IRQ_ENABLE_RST = 24'h000000;
  localparam logic MODE_GLOBAL_EN_RST = 1'b0;
  localparam logic [1:0] HW_CONFIG_RST = 2'h0;
  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_NS = 20;
  localparam int PULSE_NS = 166;
  localparam int PULSE_CYCLES = (PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int FRAME_US = 1000;
  localparam int FRAME_CYCLES_NOM = FRAME_US * 1000000 / CLK_NS / 1000;
  localparam int MISSED_SOF_LIMIT = 3;
  // Bus slave phase, one-hot
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_DATA = 2'b10
  } bus_phase_t;
endpackage

// *** hdl/usb_irq_logic.sv ***
// Interrupt logic of a full-speed USB device: event flags, enables, output.
// Assumes event inputs come from the USB engine on i_clk and AHB-Lite access.
//
// Contract
// - Each USB event sets its own flag; a per-source enable gates it.
// - Global enable cleared blocks every request from the interrupt output.
// - Polarity bit sets active level; mode bit picks level or pulse.
// - Reset defaults: active-low output and level signalling.
// - Pulse mode: one 9-cycle (180 ns) pulse when OR of requests rises.
// - Reading interrupt register clears reset, resume, suspend-entry, short-end, end, frame flags.
// - Endpoint flags clear only by reading that endpoint's status register.
// - Bus-state bit follows live bus condition on every read.
// - SETUP/OUT interrupts come only after the data packet is acknowledged.
// - Bulk endpoints interrupt on every ACK of OUT and IN transactions.
// - Isochronous endpoints interrupt on completion of each packet transaction.
// - Missing frame start gives pseudo frame ticks every 1 ms, enable-gated.
// - Three consecutive missed frame starts enter the suspend state.
// - Endpoint flags at bits 23..8, bus state at 7, events at 6..0; 31..24 read zero.
// - Transfer-end flag on DMA count zero; short-end on short packet.
//
// The AHB-Lite slave port and the address map were decided locally.
`timescale 1ns/10ps
module usb_irq_logic import usb_irq_pkg::*; #(
  parameter int FRAME_CYCLES = FRAME_CYCLES_NOM
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_clk_en,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  input wire logic i_bus_reset_evt,
  input wire logic i_resume_evt,
  input wire logic i_sof_evt,
  input wire logic i_dma_count_zero,
  input wire logic i_short_packet_end,
  input wire logic i_bus_suspended,
  input wire logic [NUM_EP-1:0] i_ep_ack,
  input wire logic [NUM_EP-1:0] i_ep_xact_done,
  input wire logic [NUM_EP-1:0] i_ep_iso,
  output logic o_irq,
  output logic o_suspend
);
  localparam int FRAME_W = $clog2(FRAME_CYCLES + 1);
  localparam logic [FRAME_W-1:0] FRAME_LAST = FRAME_W'(FRAME_CYCLES - 1);
  localparam logic [1:0] MISS_LAST = 2'(MISSED_SOF_LIMIT - 1);
  localparam logic [3:0] PULSE_LOAD = 4'(PULSE_CYCLES);

  bus_phase_t phase;
  logic [ADDR_W-1:0] addr_q;
  logic wr_q;
  logic [FLAG_W-1:0] irq_enable;
  logic global_irq_enable;
  logic irq_polarity_select;
  logic irq_signal_mode_select;
  logic hw_written;
  logic [EVT_W-1:0] evt_flags;
  logic [NUM_EP-1:0] ep_flags;
  logic [NUM_EP-1:0] next_ep_flags;
  logic [EVT_W-1:0] evt_set;
  logic [EVT_W-1:0] evt_clr;
  logic [FLAG_W-1:0] status_value;
  logic [31:0] rd_value;
  logic accept;
  logic rd_done;
  logic wr_done;
  logic rd_status_done;
  logic ep_page;
  logic [FRAME_W-1:0] frame_cnt;
  logic [1:0] miss_cnt;
  logic frame_armed;
  logic frame_expire;
  logic miss_to_suspend;
  logic bus_susp_prev;
  logic req;
  logic req_prev;
  logic [3:0] pulse_cnt;
  logic [3:0] next_pulse_cnt;
  logic next_active;

  // --------------------------------------------------------------------
  // AHB-Lite slave: one wait state, data registered
  // --------------------------------------------------------------------
  assign accept = i_hsel && i_htrans[1] && i_hready && (phase == BUS_IDLE);
  assign rd_done = (phase == BUS_DATA) && !wr_q;
  assign wr_done = (phase == BUS_DATA) && wr_q;
  assign rd_status_done = rd_done && (addr_q == OFS_IRQ_STATUS);
  assign ep_page = (addr_q[7:6] == EP_STATUS_PAGE);

  // Phase tracking; a stalled data phase keeps the master off the bus
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      phase <= BUS_IDLE;
      addr_q <= '0;
      wr_q <= 1'b0;
      o_hreadyout <= 1'b1;
      o_hrdata <= '0;
      o_hresp <= 1'b0;
    end else if (i_clk_en) begin
      case (phase)
        BUS_IDLE: begin
          if (accept) begin
            phase <= BUS_DATA;
            addr_q <= i_haddr[ADDR_W-1:0];
            wr_q <= i_hwrite;
            o_hreadyout <= 1'b0;
          end
        end
        BUS_DATA: begin
          phase <= BUS_IDLE;
          o_hreadyout <= 1'b1;
          if (!wr_q) begin
            o_hrdata <= rd_value;
          end
        end
        default: begin
          phase <= BUS_IDLE;
          o_hreadyout <= 1'b1;
        end
      endcase
    end
  end

  // Read mux; unmapped words read zero with an OKAY answer
  assign status_value = {ep_flags, i_bus_suspended, evt_flags};
  always_comb begin
    rd_value = '0;
    case (addr_q)
      OFS_IRQ_STATUS: rd_value = {8'h00, status_value};
      OFS_IRQ_ENABLE: rd_value = {8'h00, irq_enable};
      OFS_MODE: rd_value = {31'h0, global_irq_enable};
      OFS_HW_CONFIG: rd_value = {30'h0, irq_signal_mode_select, irq_polarity_select};
      default: begin
        if (ep_page) begin
          rd_value = {31'h0, ep_flags[addr_q[5:2]]};
        end
      end
    endcase
  end

  // --------------------------------------------------------------------
  // Software-written registers
  // --------------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_enable <= IRQ_ENABLE_RST;
      global_irq_enable <= MODE_GLOBAL_EN_RST;
      irq_polarity_select <= HW_CONFIG_RST[CFG_POL_BIT];
      irq_signal_mode_select <= HW_CONFIG_RST[CFG_PULSE_BIT];
      hw_written <= 1'b0;
    end else if (i_clk_en && wr_done) begin
      case (addr_q)
        OFS_IRQ_ENABLE: irq_enable <= i_hwdata[FLAG_W-1:0] & IRQ_SRC_MASK;
        OFS_MODE: global_irq_enable <= i_hwdata[MODE_GLOBAL_EN_BIT];
        OFS_HW_CONFIG: begin
          irq_polarity_select <= i_hwdata[CFG_POL_BIT];
          irq_signal_mode_select <= i_hwdata[CFG_PULSE_BIT];
          hw_written <= 1'b1;
        end
        default: hw_written <= hw_written;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Frame timer: pseudo ticks and missed-frame suspend
  // --------------------------------------------------------------------
  // Armed only after a real frame start, so an idle bus never ticks
  assign frame_expire = frame_armed && (frame_cnt == FRAME_LAST) && !i_sof_evt
    && !i_bus_reset_evt;
  assign miss_to_suspend = frame_expire && (miss_cnt == MISS_LAST);

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      frame_cnt <= '0;
      miss_cnt <= '0;
      frame_armed <= 1'b0;
      o_suspend <= 1'b0;
    end else if (i_clk_en) begin
      if (i_bus_reset_evt) begin
        frame_cnt <= '0;
        miss_cnt <= '0;
        frame_armed <= 1'b0;
        o_suspend <= 1'b0;
      end else if (i_sof_evt) begin
        frame_cnt <= '0;
        miss_cnt <= '0;
        frame_armed <= 1'b1;
        o_suspend <= 1'b0;
      end else if (miss_to_suspend) begin
        frame_cnt <= '0;
        miss_cnt <= '0;
        frame_armed <= 1'b0;
        o_suspend <= 1'b1;
      end else if (frame_expire) begin
        frame_cnt <= '0;
        miss_cnt <= miss_cnt + 2'h1;
      end else if (frame_armed) begin
        frame_cnt <= frame_cnt + FRAME_W'(1);
      end
      if (i_resume_evt && !i_sof_evt && !i_bus_reset_evt) begin
        o_suspend <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------
  // Event flags: set wins over clear-on-read
  // --------------------------------------------------------------------
  always_comb begin
    evt_set = '0;
    evt_set[BIT_BUS_RESET] = i_bus_reset_evt;
    evt_set[BIT_RESUME] = i_resume_evt;
    evt_set[BIT_SUSPEND_ENTRY] = (i_bus_suspended && !bus_susp_prev) || miss_to_suspend;
    evt_set[BIT_XFER_END] = i_dma_count_zero;
    evt_set[BIT_SOF] = i_sof_evt;
    evt_set[BIT_PSEUDO] = frame_expire;
    evt_set[BIT_SHORT_END] = i_short_packet_end;
  end
  // Clear only what the finishing read returned; later events stay
  assign evt_clr = rd_status_done ? (evt_flags & CLEAR_ON_READ) : '0;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      evt_flags <= '0;
      bus_susp_prev <= 1'b0;
    end else if (i_clk_en) begin
      evt_flags <= (evt_flags & ~evt_clr) | evt_set;
      bus_susp_prev <= i_bus_suspended;
    end
  end

  // Endpoint flags, each cleared by its own status register read
  for (genvar n = 0; n < NUM_EP; n++) begin : g_ep
    logic ep_set;
    logic ep_clr;
    // Engine pulses ACK only once the data packet is acknowledged
    assign ep_set = i_ep_iso[n] ? i_ep_xact_done[n] : i_ep_ack[n];
    assign ep_clr = rd_done && ep_page && (addr_q[5:2] == 4'(n));
    assign next_ep_flags[n] = ep_set || (ep_flags[n] && !ep_clr);
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ep_flags <= '0;
    end else if (i_clk_en) begin
      ep_flags <= next_ep_flags;
    end
  end

  // --------------------------------------------------------------------
  // Interrupt output: level or fixed pulse, selectable polarity
  // --------------------------------------------------------------------
  assign req = global_irq_enable && |({ep_flags, 1'b0, evt_flags} & irq_enable);

  // Retrigger is ignored while a pulse runs; the host sees one edge anyway
  always_comb begin
    next_pulse_cnt = pulse_cnt;
    if (req && !req_prev && pulse_cnt == 4'h0) begin
      next_pulse_cnt = PULSE_LOAD;
    end else if (pulse_cnt != 4'h0) begin
      next_pulse_cnt = pulse_cnt - 4'h1;
    end
    next_active = irq_signal_mode_select ? (next_pulse_cnt != 4'h0) : req;
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      req_prev <= 1'b0;
      pulse_cnt <= '0;
      o_irq <= 1'b1;
    end else if (i_clk_en) begin
      req_prev <= req;
      pulse_cnt <= next_pulse_cnt;
      o_irq <= irq_polarity_select ? next_active : !next_active;
    end
  end

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  a_global_mask_off: assert property (
    i_clk_en && !global_irq_enable && pulse_cnt == 4'h0 |=> o_irq != irq_polarity_select
  ) else $error("interrupt active with global enable off");

  a_level_hold: assert property (
    i_clk_en && !irq_signal_mode_select && req |=> o_irq == $past(irq_polarity_select)
  ) else $error("level interrupt not active while request stands");

  a_reset_defaults: assert property (
    !hw_written |-> !irq_polarity_select && !irq_signal_mode_select
  ) else $error("configuration not at reset defaults");

  // Length of the active stretch in pulse mode; 0xf marks a stretch of unknown start
  logic [3:0] active_run;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      active_run <= '0;
    end else if (i_clk_en) begin
      if (!irq_signal_mode_select) begin
        active_run <= 4'hf;
      end else if (o_irq != irq_polarity_select) begin
        active_run <= '0;
      end else if (active_run != 4'hf) begin
        active_run <= active_run + 4'h1;
      end
    end
  end

  a_pulse_width: assert property (
    i_clk_en && irq_signal_mode_select && $stable(irq_polarity_select)
      && active_run != 4'h0 && active_run != 4'hf && o_irq != irq_polarity_select
      |-> active_run == PULSE_LOAD
  ) else $error("pulse width wrong");

  a_read_clears: assert property (
    i_clk_en && rd_status_done && !i_bus_reset_evt |=> !evt_flags[BIT_BUS_RESET]
  ) else $error("bus reset flag survived read");

  a_read_keeps_ep: assert property (
    i_clk_en && rd_status_done && ep_flags[0] |=> ep_flags[0]
  ) else $error("endpoint flag cleared by interrupt register read");

  a_live_bus_state: assert property (
    i_clk_en && rd_status_done |=> o_hrdata[BIT_BUS_STATE] == $past(i_bus_suspended)
  ) else $error("bus state bit not live");

  a_bulk_ack_flag: assert property (
    i_clk_en && i_ep_ack[2] && !i_ep_iso[2] |=> ep_flags[2]
  ) else $error("bulk ACK did not raise endpoint flag");

  a_iso_done_flag: assert property (
    i_clk_en && i_ep_xact_done[3] && i_ep_iso[3] |=> ep_flags[3]
  ) else $error("isochronous completion did not raise flag");

  a_pseudo_tick: assert property (
    i_clk_en && frame_expire |=> evt_flags[BIT_PSEUDO]
  ) else $error("missed frame gave no pseudo tick");

  a_third_miss: assert property (
    i_clk_en && frame_expire && miss_cnt == 2'h2 && !i_resume_evt |=> o_suspend
  ) else $error("third missed frame did not suspend");

  a_dma_end: assert property (
    i_clk_en && i_dma_count_zero |=> evt_flags[BIT_XFER_END]
  ) else $error("transfer end flag not set");

  a_set_beats_clear: assert property (
    i_clk_en && rd_status_done && i_sof_evt |=> evt_flags[BIT_SOF]
  ) else $error("frame event lost during read");

  c_pulse_mode: cover property (irq_signal_mode_select && pulse_cnt == PULSE_LOAD);
  c_suspend_entry: cover property (miss_to_suspend);
  c_status_read: cover property (rd_status_done && evt_flags != '0);
  c_ep_clear: cover property (rd_done && ep_page && ep_flags != '0);
endmodule

// *** verif/irq_sink.sv ***
// Host interrupt input model: counts entries into the active level.
// Assumes the bench tells it the polarity that firmware has configured.
`timescale 1ns/10ps
module irq_sink (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_irq,
  input wire logic i_active_high,
  output int o_count
);
  logic prev_active;
  // Edge-sensitive view, so a stretched pulse still counts once
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      prev_active <= 1'b0;
      o_count <= 0;
    end else begin
      prev_active <= (i_irq == i_active_high);
      if ((i_irq == i_active_high) && !prev_active) begin
        o_count <= o_count + 1;
      end
    end
  end
endmodule

// *** verif/usb_device_interrupt_logic_bench.sv ***
// Self-checking bench for the USB interrupt logic with a flag model.
// Assumes a 50 MHz clock; the bench is the only AHB-Lite master.
`timescale 1ns/10ps
module usb_device_interrupt_logic_bench;
  import usb_irq_pkg::*;
  localparam int FRM = 40;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic clk_en = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic [4:0] ev = 5'h00; // short, sof, dma, resume, bus reset
  logic bus_susp = 1'b0;
  logic [15:0] ep_ack = 16'h0;
  logic [15:0] ep_done = 16'h0;
  logic [15:0] ep_iso = 16'h0;
  logic [31:0] hrdata, rd, exp_st;
  logic hreadyout, hresp, irq, susp, pol;
  int sink_count, cnt, base;
  int bad_count = 0;
  int n_checks = 0;

  usb_irq_logic #(.FRAME_CYCLES(FRM)) u_dut (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_clk_en(clk_en), .i_hsel(hsel),
    .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
    .i_hwdata(hwdata), .i_hready(hreadyout), .o_hrdata(hrdata),
    .o_hreadyout(hreadyout), .o_hresp(hresp), .i_bus_reset_evt(ev[0]),
    .i_resume_evt(ev[1]), .i_sof_evt(ev[3]), .i_dma_count_zero(ev[2]),
    .i_short_packet_end(ev[4]), .i_bus_suspended(bus_susp), .i_ep_ack(ep_ack),
    .i_ep_xact_done(ep_done), .i_ep_iso(ep_iso), .o_irq(irq), .o_suspend(susp)
  );
  irq_sink u_sink (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_irq(irq), .i_active_high(pol),
    .o_count(sink_count)
  );

  // Free-running core clock
  always #10 i_clk = ~i_clk;

  // ----------------------------------------------------------------------
  // Checking and bus tasks
  // ----------------------------------------------------------------------
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    n_checks++;
    if (seen !== want) begin
      bad_count++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, seen, want);
    end
  endtask
  // Bounded wait, a hung slave ends the run
  task automatic wait_ready();
    int k;
    k = 0;
    do begin
      @(posedge i_clk);
      k++;
      if (k > 50) begin
        bad_count++;
        print_verdict();
      end
    end while (hreadyout !== 1'b1);
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge i_clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] want);
    bus(1'b0, a, 32'h0);
    chk(rd, want);
  endtask
  // Whole-word read; model drops the clear-on-read bits afterwards
  task automatic st_read();
    bus(1'b0, OFS_IRQ_STATUS, 32'h0);
    chk(rd, exp_st | {24'h0, bus_susp, 7'h0});
    chk({31'h0, hresp}, 32'h0);
    exp_st = exp_st & ~32'h7f;
  endtask
  task automatic fire(input logic [4:0] e);
    @(posedge i_clk);
    ev <= e;
    @(posedge i_clk);
    ev <= 5'h00;
    exp_st = exp_st | {25'h0, e[4], 1'b0, e[3], e[2], 1'b0, e[1], e[0]};
  endtask
  task automatic ep_evt(input int n, input logic iso);
    @(posedge i_clk);
    ep_iso[n] <= iso;
    if (iso) begin
      ep_done[n] <= 1'b1;
    end else begin
      ep_ack[n] <= 1'b1;
    end
    @(posedge i_clk);
    ep_ack <= 16'h0;
    ep_done <= 16'h0;
    exp_st[BIT_EP_BASE + n] = 1'b1;
  endtask
  task automatic irq_chk(input logic act);
    repeat (2) @(posedge i_clk);
    #1 chk({31'h0, irq}, {31'h0, act ~^ pol});
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    cnt = $urandom(55882);
    exp_st = 32'h0;
    pol = 1'b0;
    repeat (10) @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(posedge i_clk);
    #1 chk({31'h0, irq}, 32'h1);
    rdchk(OFS_HW_CONFIG, 32'h0);
    rdchk(OFS_MODE, 32'h0);
    rdchk(OFS_IRQ_ENABLE, 32'h0);
    bus(1'b1, OFS_IRQ_ENABLE, 32'hffffffff);
    rdchk(OFS_IRQ_ENABLE, {8'h0, IRQ_SRC_MASK});
    rdchk(8'h30, 32'h0);
    fire(5'h04);
    irq_chk(1'b0);
    bus(1'b1, OFS_MODE, 32'h1);
    irq_chk(1'b1);
    st_read();
    irq_chk(1'b0);
    // Only bus reset enabled: the transfer end is logged but silent
    bus(1'b1, OFS_IRQ_ENABLE, 32'h1);
    fire(5'h04);
    irq_chk(1'b0);
    fire(5'h01);
    irq_chk(1'b1);
    st_read();
    bus(1'b1, OFS_IRQ_ENABLE, 32'hffffffff);
    // Every endpoint, alternating bulk and isochronous
    for (int n = 0; n < NUM_EP; n++) begin
      ep_evt(n, n[0]);
    end
    irq_chk(1'b1);
    st_read();
    st_read();
    for (int n = 0; n < NUM_EP; n++) begin
      rdchk(8'h40 + 8'(4 * n), 32'h1);
      exp_st[BIT_EP_BASE + n] = 1'b0;
    end
    st_read();
    irq_chk(1'b0);
    @(posedge i_clk);
    bus_susp <= 1'b1;
    exp_st[BIT_SUSPEND_ENTRY] = 1'b1;
    st_read();
    bus_susp <= 1'b0;
    st_read();
    // Pulse mode, active high; a second event while set must not pulse
    pol = 1'b1;
    bus(1'b1, OFS_HW_CONFIG, 32'h3);
    for (int r = 0; r < 3; r++) begin
      base = sink_count;
      cnt = 0;
      fire(5'h04);
      repeat (20) begin
        @(posedge i_clk);
        #1 cnt = cnt + int'(irq === 1'b1);
      end
      chk(cnt, (r == 1) ? 0 : PULSE_CYCLES);
      chk(sink_count - base, (r == 1) ? 0 : 1);
      if (r == 1) begin
        st_read();
      end
    end
    st_read();
    // Frozen clock enable: an event pulse in that time is not seen
    clk_en <= 1'b0;
    fire(5'h04);
    clk_en <= 1'b1;
    exp_st[BIT_XFER_END] = 1'b0;
    st_read();
    // Random events in level mode with random polarity
    for (int i = 0; i < 12; i++) begin
      pol = 1'($urandom);
      bus(1'b1, OFS_HW_CONFIG, {31'h0, pol});
      fire(5'($urandom) & 5'h17);
      irq_chk(exp_st[6:0] != 7'h0);
      st_read();
    end
    // Missed frames: pseudo ticks, then suspend on the third
    pol = 1'b0;
    bus(1'b1, OFS_HW_CONFIG, 32'h0);
    // Frame-driven handling: the isochronous endpoint stays silent
    bus(1'b1, OFS_IRQ_ENABLE, 32'h30);
    ep_evt(3, 1'b1);
    irq_chk(1'b0);
    // Frame start landing in the clearing edge of a read must survive
    fork
      st_read();
      begin
        repeat (2) @(posedge i_clk);
        ev <= 5'h08;
        @(posedge i_clk);
        ev <= 5'h00;
      end
    join
    exp_st[BIT_SOF] = 1'b1;
    fire(5'h08);
    repeat (2 * FRM + 10) @(posedge i_clk);
    #1 chk({31'h0, susp}, 32'h0);
    exp_st = exp_st | 32'h20;
    st_read();
    repeat (FRM) @(posedge i_clk);
    #1 chk({31'h0, susp}, 32'h1);
    irq_chk(1'b1);
    exp_st = exp_st | 32'h24;
    st_read();
    fire(5'h01);
    repeat (2) @(posedge i_clk);
    #1 chk({31'h0, susp}, 32'h0);
    print_verdict();
  end
endmodule
